/* common/eac_pkg.sv */
// constants and types for the nonvolatile access controller
package eac_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int OSC_HZ = 1_000_000;
  localparam int OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int WRITE_OSC_CYCLES = 8448;
  localparam int ARM_WINDOW_CYCLES = 4;
  localparam int WRITE_STALL_CYCLES = 2;
  localparam int READ_STALL_CYCLES = 4;
  localparam int NV_ADDR_W = 11;
  localparam int NV_DEPTH = 2048;
  localparam int APB_AW = 8;
  localparam int EVT_W = 3;
  localparam int STALL_W = 3;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h1c;
  localparam logic [5:0] IDX_DATA = 6'h1d;
  localparam logic [5:0] IDX_ADDR_LOW = 6'h1e;
  localparam logic [5:0] IDX_ADDR_HIGH = 6'h1f;
  localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [5:0] IDX_IRQ_CLEAR = 6'h21;
  localparam logic [5:0] IDX_IRQ_ENABLE = 6'h22;

  // reset values
  localparam logic [NV_ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic RIE_RST = 1'b0;
  localparam logic [EVT_W-1:0] IRQ_ENABLE_RST = 3'h0;
  localparam logic [EVT_W-1:0] IRQ_STATUS_RST = 3'h0;

  // control register, bits 3:0; bits 7:4 read zero
  typedef struct packed {
    logic rie;
    logic arm;
    logic strobe;
    logic read;
  } eac_ctrl_t;

  // sticky events, bits 2:0 of status, clear and enable
  typedef struct packed {
    logic read_refused;
    logic write_refused;
    logic write_done;
  } eac_evt_t;

  typedef enum logic [0:0] {
    WR_IDLE,
    WR_PROG
  } eac_wr_state_t;

  function automatic logic [APB_AW-1:0] byte_addr(input logic [5:0] idx);
    return {idx, 2'b00};
  endfunction
endpackage

/* rtl/eac_top.sv */
// nonvolatile byte array with apb register access and timed writes
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - 11-bit linear address selects one of 2K bytes
// - unused high address and control bits read zero
// - data byte feeds writes, holds read result
// - ready interrupt level while enabled and idle
// - write arm clears itself after four cycles
// - strobe starts write only while armed
// - strobe bit stays set until write completes
// - write start stalls cpu two cycles
// - read strobe fetches byte into data immediately
// - read strobe stalls cpu four cycles
// - busy write refuses reads, freezes address
// - write lasts 8448 one-megahertz oscillator ticks
// - write pauses during flash self-programming
module eac_top
  import eac_pkg::*;
#(
  parameter int WRITE_OSC_CYCLES_P = WRITE_OSC_CYCLES
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // core side
  input  wire logic              core_irq_enable,
  input  wire logic              self_prog_active,
  output logic                   cpu_stall,
  output logic                   ready_irq,
  output logic                   irq
);

  localparam int OSC_W = $clog2(WRITE_OSC_CYCLES_P + 1);
  localparam int DIV_W = $clog2(OSC_DIV + 1);
  localparam int WRITE_PCLK_CYCLES = WRITE_OSC_CYCLES_P * OSC_DIV;
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(WRITE_OSC_CYCLES_P - 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
  localparam logic [2:0] ARM_LAST = 3'(ARM_WINDOW_CYCLES - 1);

  // full byte match: misaligned addresses fall through to the error response
  function automatic logic hit(input logic [APB_AW-1:0] a, input logic [5:0] idx);
    return a == byte_addr(idx);
  endfunction

  function automatic logic mapped(input logic [APB_AW-1:0] a);
    return hit(a, IDX_CTRL) || hit(a, IDX_DATA) || hit(a, IDX_ADDR_LOW) ||
           hit(a, IDX_ADDR_HIGH) || hit(a, IDX_IRQ_STATUS) ||
           hit(a, IDX_IRQ_CLEAR) || hit(a, IDX_IRQ_ENABLE);
  endfunction

  logic [7:0]           mem [NV_DEPTH];
  logic [NV_ADDR_W-1:0] addr_reg;
  logic [7:0]           data_reg;
  logic [7:0]           prog_data_reg;
  logic                 rie_reg;
  logic                 arm_reg;
  logic [2:0]           arm_cnt_reg;
  eac_wr_state_t        state_reg;
  logic [DIV_W-1:0]     div_cnt_reg;
  logic [OSC_W-1:0]     osc_cnt_reg;
  logic [STALL_W-1:0]   stall_cnt_reg;
  logic [STALL_W-1:0]   stall_next;
  eac_evt_t             status_reg;
  eac_evt_t             status_next;
  eac_evt_t             enable_reg;
  eac_evt_t             evt;
  eac_ctrl_t            ctrl_w;
  logic                 busy;
  logic                 wr_en;
  logic                 wr_ctrl;
  logic                 start;
  logic                 read_go;
  logic                 tick;
  logic                 wr_done;
  logic [31:0]          rd_mux;

  assign busy    = state_reg == WR_PROG;
  assign wr_en   = psel && penable && pready && pwrite;
  assign ctrl_w  = eac_ctrl_t'(pwdata[3:0]);
  assign wr_ctrl = wr_en && hit(paddr, IDX_CTRL);
  assign start   = wr_ctrl && ctrl_w.strobe && arm_reg && !busy;
  assign read_go = wr_ctrl && ctrl_w.read && !busy;
  // the oscillator tick is made from pclk, so the count lives in pclk's domain
  assign tick    = busy && !self_prog_active && div_cnt_reg == DIV_LAST;
  assign wr_done = tick && osc_cnt_reg == OSC_LAST;

  assign evt.read_refused  = wr_ctrl && ctrl_w.read && busy;
  assign evt.write_refused = wr_ctrl && ctrl_w.strobe && !arm_reg && !busy;
  assign evt.write_done    = wr_done;

  // apb: answer one cycle after setup, read data captured at setup
  always_comb begin
    rd_mux = 32'h0;
    if (hit(paddr, IDX_ADDR_LOW)) begin
      rd_mux = {24'h0, addr_reg[7:0]};
    end else if (hit(paddr, IDX_ADDR_HIGH)) begin
      rd_mux = {29'h0, addr_reg[10:8]};
    end else if (hit(paddr, IDX_DATA)) begin
      rd_mux = {24'h0, data_reg};
    end else if (hit(paddr, IDX_CTRL)) begin
      rd_mux = {28'h0, rie_reg, arm_reg, busy, 1'b0};
    end else if (hit(paddr, IDX_IRQ_STATUS)) begin
      rd_mux = {29'h0, status_reg};
    end else if (hit(paddr, IDX_IRQ_ENABLE)) begin
      rd_mux = {29'h0, enable_reg};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0 : rd_mux;
        pslverr <= !mapped(paddr);
      end
    end
  end

  // address frozen while a write runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_reg <= ADDR_RST;
    end else if (wr_en && !busy) begin
      if (hit(paddr, IDX_ADDR_LOW)) begin
        addr_reg[7:0] <= pwdata[7:0];
      end else if (hit(paddr, IDX_ADDR_HIGH)) begin
        addr_reg[10:8] <= pwdata[2:0];
      end
    end
  end

  // data byte: software load or read fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= DATA_RST;
    end else if (read_go) begin
      data_reg <= mem[addr_reg];
    end else if (wr_en && hit(paddr, IDX_DATA)) begin
      data_reg <= pwdata[7:0];
    end
  end

  // array has no reset; contents are whatever was last programmed
  always_ff @(posedge pclk) begin
    if (wr_done) begin
      mem[addr_reg] <= prog_data_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rie_reg <= RIE_RST;
    end else if (wr_ctrl) begin
      rie_reg <= ctrl_w.rie;
    end
  end

  // arm window: a fresh arm write restarts the four cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_reg     <= 1'b0;
      arm_cnt_reg <= 3'h0;
    end else if (wr_ctrl && ctrl_w.arm && !ctrl_w.strobe) begin
      arm_reg     <= 1'b1;
      arm_cnt_reg <= ARM_LAST;
    end else if (arm_reg && arm_cnt_reg == 3'h0) begin
      arm_reg <= 1'b0;
    end else if (arm_reg) begin
      arm_cnt_reg <= arm_cnt_reg - 3'h1;
    end
  end

  // write sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= WR_IDLE;
      prog_data_reg <= DATA_RST;
    end else begin
      unique case (state_reg)
        WR_IDLE: begin
          if (start) begin
            state_reg     <= WR_PROG;
            prog_data_reg <= data_reg;
          end
        end
        WR_PROG: begin
          if (wr_done) begin
            state_reg <= WR_IDLE;
          end
        end
      endcase
    end
  end

  // divider stands still while flash self-programming runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= '0;
      osc_cnt_reg <= '0;
    end else if (!busy) begin
      div_cnt_reg <= '0;
      osc_cnt_reg <= '0;
    end else if (!self_prog_active) begin
      if (tick) begin
        div_cnt_reg <= '0;
        osc_cnt_reg <= osc_cnt_reg + OSC_W'(1);
      end else begin
        div_cnt_reg <= div_cnt_reg + DIV_W'(1);
      end
    end
  end

  // cpu stall
  always_comb begin
    stall_next = '0;
    if (read_go) begin
      stall_next = STALL_W'(READ_STALL_CYCLES);
    end else if (start) begin
      stall_next = STALL_W'(WRITE_STALL_CYCLES);
    end else if (stall_cnt_reg != '0) begin
      stall_next = stall_cnt_reg - STALL_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt_reg <= '0;
      cpu_stall     <= 1'b0;
    end else begin
      stall_cnt_reg <= stall_next;
      cpu_stall     <= stall_next != '0;
    end
  end

  // ready level follows rie, core_irq_enable and not busy, one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= rie_reg && core_irq_enable && !busy;
    end
  end

  // sticky events: a new event wins over a clear in the same cycle
  always_comb begin
    status_next = status_reg;
    if (wr_en && hit(paddr, IDX_IRQ_CLEAR)) begin
      status_next = status_reg & ~eac_evt_t'(pwdata[EVT_W-1:0]);
    end
    status_next = status_next | evt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= IRQ_STATUS_RST;
      enable_reg <= IRQ_ENABLE_RST;
      irq        <= 1'b0;
    end else begin
      status_reg <= status_next;
      if (wr_en && hit(paddr, IDX_IRQ_ENABLE)) begin
        enable_reg <= eac_evt_t'(pwdata[EVT_W-1:0]);
      end
      irq <= |(status_reg & enable_reg);
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // pclk cycles of an unpaused write, for the duration check
  int len_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_cnt <= 0;
    end else if (!busy) begin
      len_cnt <= 0;
    end else if (!self_prog_active) begin
      len_cnt <= len_cnt + 1;
    end
  end

  a_high_addr_zero: assert property (
    pready && psel && !pwrite && hit(paddr, IDX_ADDR_HIGH) |-> prdata[31:3] == 29'h0)
    else $error("address high reserved bits not zero");
  a_ctrl_rsv_zero: assert property (
    pready && psel && !pwrite && hit(paddr, IDX_CTRL) |-> prdata[7:4] == 4'h0 && !prdata[0])
    else $error("control reserved bits not zero");
  a_ready_level: assert property (
    rie_reg && core_irq_enable && !busy ##1 $stable(rie_reg) |-> ready_irq)
    else $error("ready interrupt missing while idle and enabled");
  a_ready_busy: assert property (
    $past(busy) |-> !ready_irq)
    else $error("ready interrupt during write");
  a_arm_timeout: assert property (
    $rose(arm_reg) && !(wr_ctrl && ctrl_w.arm) ##1 !(wr_ctrl && ctrl_w.arm) [*3] |-> arm_reg ##1 !arm_reg)
    else $error("arm window not four cycles");
  a_strobe_unarmed: assert property (
    wr_ctrl && ctrl_w.strobe && !arm_reg && !busy |=> !busy)
    else $error("write started without arm");
  a_strobe_starts: assert property (
    wr_ctrl && ctrl_w.strobe && arm_reg && !busy |=> busy)
    else $error("armed strobe did not start write");
  a_write_stall: assert property (
    start && !read_go |=> cpu_stall [*2] ##1 (!cpu_stall || $past(read_go)))
    else $error("write stall not two cycles");
  a_read_stall: assert property (
    read_go |=> cpu_stall [*4])
    else $error("read stall shorter than four cycles");
  a_read_fetch: assert property (
    read_go |=> data_reg == mem[addr_reg])
    else $error("read strobe did not fetch byte");
  a_addr_frozen: assert property (
    busy && $past(busy) |-> $stable(addr_reg))
    else $error("address changed during write");
  a_write_commit: assert property (
    $past(wr_done) |-> mem[addr_reg] == prog_data_reg && !busy)
    else $error("programmed byte not stored");
  a_write_length: assert property (
    $fell(busy) |-> len_cnt == WRITE_PCLK_CYCLES)
    else $error("write duration wrong");
  a_self_prog_hold: assert property (
    busy && self_prog_active |=> busy)
    else $error("write finished during self-programming");

  // refusals and bookkeeping around a running write
  a_busy_readback: assert property (
    pready && psel && !pwrite && hit(paddr, IDX_CTRL) |-> prdata[1] == $past(busy))
    else $error("strobe bit does not show write in progress");
  a_refused_read: assert property (
    wr_ctrl && ctrl_w.read && busy |=> $stable(data_reg))
    else $error("read strobe fetched during write");
  a_data_latched: assert property (
    start |=> prog_data_reg == $past(data_reg))
    else $error("programmed byte not taken from data register");
  a_arm_source: assert property (
    $rose(arm_reg) |-> $past(wr_ctrl) && $past(ctrl_w.arm) && !$past(ctrl_w.strobe))
    else $error("arm set without an arm write");
  a_ready_masked: assert property (
    !core_irq_enable |=> !ready_irq)
    else $error("ready interrupt while globally masked");
  a_ready_falls: assert property (
    $rose(busy) |=> !ready_irq)
    else $error("ready interrupt stays up after write start");
  a_done_sticky: assert property (
    wr_done |=> status_reg.write_done && !busy)
    else $error("write completion not recorded");

  c_write_done: cover property (wr_done);
  c_read_fetch: cover property (read_go ##1 cpu_stall [*4]);
  c_refused: cover property (evt.write_refused);
  c_irq: cover property (ready_irq && irq);
  c_pause_write: cover property (busy && self_prog_active ##1 busy && !self_prog_active);

endmodule

`default_nettype wire

/* tb/eac_top_tb.sv */
// self-checking bench for the nonvolatile access controller
`timescale 1ns/100ps
`default_nettype none
module eac_top_tb;
  import eac_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, err;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic              pready, pslverr, core_irq_enable, self_prog_active;
  logic              cpu_stall, ready_irq, irq;
  logic [10:0]       a;
  logic [7:0]        d;
  int                bad_count, tests_run, seed, run, last_run, i;

  eac_top #(.WRITE_OSC_CYCLES_P(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_irq_enable(core_irq_enable), .self_prog_active(self_prog_active),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq), .irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // length of the last completed stall run
  always @(posedge pclk) begin
    if (cpu_stall === 1'b1) run++;
    else begin
      if (run != 0) last_run = run;
      run = 0;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one transfer, then an idle edge so strobes never toggle twice per step
  task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; the watchdog ends a hung access
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic set_addr(input logic [10:0] wa);
    apb(1'b1, IDX_ADDR_LOW, {24'h0, wa[7:0]});
    apb(1'b1, IDX_ADDR_HIGH, {24'h0, 5'h1f, wa[10:8]});
    apb(1'b0, IDX_ADDR_HIGH, 32'h0);
    chk(rd, {29'h0, wa[10:8]}, "addr high");
  endtask

  task automatic nv_write(input logic [10:0] wa, input logic [7:0] wv, input logic pause);
    int n;
    core_irq_enable <= 1'b0;
    set_addr(wa);
    apb(1'b1, IDX_DATA, {24'h0, wv});
    apb(1'b1, IDX_CTRL, 32'hc);
    last_run = 0;
    apb(1'b1, IDX_CTRL, 32'ha);
    core_irq_enable <= 1'b1;
    self_prog_active <= pause;
    apb(1'b0, IDX_CTRL, 32'h0);
    chk(rd & ~32'h4, 32'ha, "busy");
    chk({31'h0, ready_irq}, 32'h0, "ready irq busy");
    chk(last_run, 32'd2, "write stall");
    apb(1'b1, IDX_ADDR_LOW, {24'h0, ~wa[7:0]});
    apb(1'b1, IDX_CTRL, 32'h9);
    repeat (pause ? 60 : 20) @(posedge pclk);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk({31'h0, rd[1]}, 32'h1, "still busy");
    self_prog_active <= 1'b0;
    n = 0;
    do begin
      apb(1'b0, IDX_CTRL, 32'h0);
      n++;
    end while (rd[1] !== 1'b0 && n < 100);
    chk({31'h0, rd[1]}, 32'h0, "write finished");
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    chk(rd, 32'h5, "status");
    chk({31'h0, irq}, 32'h1, "irq set");
    chk({31'h0, ready_irq}, 32'h1, "ready irq idle");
    apb(1'b1, IDX_IRQ_CLEAR, 32'h7);
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    chk(rd, 32'h0, "status clear");
    chk({31'h0, irq}, 32'h0, "irq clear");
    apb(1'b0, IDX_ADDR_LOW, 32'h0);
    chk(rd, {24'h0, wa[7:0]}, "addr frozen");
  endtask

  task automatic nv_read(input logic [10:0] wa, input logic [7:0] ev);
    set_addr(wa);
    last_run = 0;
    apb(1'b1, IDX_CTRL, 32'h9);
    apb(1'b0, IDX_DATA, 32'h0);
    chk(rd, {24'h0, ev}, "read data");
    repeat (3) @(posedge pclk);
    chk(last_run, 32'd4, "read stall");
  endtask

  task automatic stop_test();
    $display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #(100 * 20000);
    bad_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    seed = 32'h8a2c;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    core_irq_enable = 1'b0;
    self_prog_active = 1'b0;
    bad_count = 0;
    tests_run = 0;
    run = 0;
    last_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk(rd, 32'h0, "ctrl reset");
    apb(1'b0, 6'h3f, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    apb(1'b1, IDX_IRQ_ENABLE, 32'h7);
    core_irq_enable <= 1'b1;
    apb(1'b1, IDX_CTRL, 32'h8);
    // ready level launches at the idle edge after the access
    @(posedge pclk);
    chk({31'h0, ready_irq}, 32'h1, "ready irq");
    apb(1'b1, IDX_CTRL, 32'ha);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk(rd, 32'h8, "strobe unarmed");
    apb(1'b1, IDX_CTRL, 32'hc);
    // arm window is gone by the time this strobe lands
    repeat (4) @(posedge pclk);
    apb(1'b1, IDX_CTRL, 32'ha);
    apb(1'b0, IDX_CTRL, 32'h0);
    chk(rd, 32'h8, "arm timeout");
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    chk(rd, 32'h2, "refused status");
    apb(1'b1, IDX_IRQ_CLEAR, 32'h7);
    $display("test reset and refusal done");
    for (i = 0; i < 4; i++) begin
      a = (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : 11'($random(seed));
      d = 8'($random(seed));
      nv_write(a, d, i == 2);
      nv_read(a, d);
      $display("test write read %0d done", i);
    end
    stop_test();
  end
endmodule
`default_nettype wire
